// >>> verilog/dpcad_regs.vh
// register map, command codes and field positions of the program-control adapter
// -----------------------------------------------------------------------------
// Notes on behaviour
// - adapter commands answer only not-attached, data-check or satisfactory codes.
// - device commands pass by direction; any of eight codes returns.
// - code 2E reads the adapter status word, 2F the diagnostic data.
// - codes 60 prepare, 61 set diagnostic, 62 reset diagnostic; exact codes only.
// - adapter commands execute inside the adapter, never reaching devices.
// - prepare takes level from data bits 27-30, enable from bit 31.
// - one level and one enable serve every device address.
// - each accepted prepare replaces earlier level and enable.
// - a prepare ending in data check leaves level and enable untouched.
// - set diagnostic enters diagnostic mode and clears the diagnostic register.
// - diagnostic mode wraps device-side control and data into the register.
// - set-diagnostic data bits select interrupt and diagnostic function.
// - set diagnostic with bit 16 zero enters local-diagnostic mode.
// - local diagnostic forces both parity-error status bits to zero.
// - local diagnostic masks device interrupts and ignores device data.
// - local diagnostic holds all device-side outputs inactive.
// - local diagnostic answers device commands itself, per selector bits 30-31.
// - selector 00 raises one attention interrupt, zero info byte, until serviced.
// - selector 01 writes copy data in; reads return zeros and clear it.
// - reset diagnostic leaves the mode, clears the register; no-op if not in.
// - status read returns 16 bits, clears parity errors; other successes too.
// -----------------------------------------------------------------------------
`ifndef DPCAD_REGS_VH
`define DPCAD_REGS_VH

// register byte offsets
`define DPCAD_OFF_CMD        8'h00
`define DPCAD_OFF_IMM        8'h04
`define DPCAD_OFF_CTRL       8'h08
`define DPCAD_OFF_RESULT     8'h0C
`define DPCAD_OFF_STATE      8'h10
`define DPCAD_OFF_DIAG       8'h14
`define DPCAD_OFF_ATTN       8'h18

// adapter command codes
`define DPCAD_CMD_RD_STATUS  8'h2E
`define DPCAD_CMD_RD_DIAG    8'h2F
`define DPCAD_CMD_PREPARE    8'h60
`define DPCAD_CMD_SET_DIAG   8'h61
`define DPCAD_CMD_RST_DIAG   8'h62
`define DPCAD_CMD_WR_BIT     6

// completion codes
`define DPCAD_CC_NOT_ATT     3'h0
`define DPCAD_CC_DATA_CHK    3'h5
`define DPCAD_CC_OK          3'h7

// immediate data fields, imm[15] is block bit 16, imm[0] is bit 31
`define DPCAD_IMM_EXT_BIT    15
`define DPCAD_IMM_LVL_HI     4
`define DPCAD_IMM_LVL_LO     1
`define DPCAD_IMM_EN_BIT     0
`define DPCAD_IMM_SEL_HI     1
`define DPCAD_IMM_SEL_LO     0

// diagnostic selector values
`define DPCAD_SEL_ATTN       2'h0
`define DPCAD_SEL_DATA       2'h1
`define DPCAD_SEL_LINES      2'h2
`define DPCAD_SEL_AND        2'h3

// control and attention register bits
`define DPCAD_CTRL_START     0
`define DPCAD_CTRL_PERR      1
`define DPCAD_ATTN_CLR       0

// reset values
`define DPCAD_RST_LEVEL      4'h0
`define DPCAD_RST_ENABLE     1'b0
`define DPCAD_RST_DIAG       16'h0000
`define DPCAD_RST_CMD        16'h0000

`endif

// >>> verilog/dpcad_ahb.v
// ahb-lite slave front end with one wait state per transfer
`timescale 1ns/100ps
`default_nettype none

module dpcad_ahb (
  input  wire        ref_clk,    // system clock
  input  wire        reset_n,    // async reset, active low
  input  wire        clk_en,     // freezes state when low
  input  wire        hsel,       // slave select
  input  wire [31:0] haddr,      // byte address
  input  wire [1:0]  htrans,     // transfer type
  input  wire        hwrite,     // write transfer
  input  wire [31:0] hwdata,     // write data
  input  wire        hready,     // bus ready
  output reg         hreadyout,  // slave ready
  output reg  [31:0] hrdata,     // read data
  output reg         hresp,      // always okay
  output wire        wr_en,      // register write strobe
  output wire [7:0]  wr_addr,    // register write offset
  output wire [31:0] wr_data,    // register write data
  output wire [7:0]  rd_addr,    // register read offset
  input  wire [31:0] rd_data     // register read value
);

  reg  [7:0] addr_q;  // latched offset
  reg        write_q; // latched direction
  reg        pend_q;  // data phase in progress
  wire       take;

  // address phase accepted on active nonseq or seq
  assign take    = hsel & hready & htrans[1];
  assign wr_en   = pend_q & write_q & clk_en;
  assign wr_addr = addr_q;
  assign wr_data = hwdata;
  assign rd_addr = addr_q;

  // -------------------------------------------------------------------------
  // transfer sequencing
  // -------------------------------------------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q    <= 8'h00;
      write_q   <= 1'b0;
      pend_q    <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      hresp <= 1'b0;
      if (take) begin
        addr_q    <= haddr[7:0];
        write_q   <= hwrite;
        pend_q    <= 1'b1;
        hreadyout <= 1'b0;
      end else if (pend_q) begin
        pend_q    <= 1'b0;
        hreadyout <= 1'b1;
        if (!write_q) begin
          hrdata <= rd_data;
        end
      end
    end
  end

endmodule // dpcad_ahb

`default_nettype wire

// >>> verilog/dpcad_top.v
// command decode and diagnostic control of the program-control adapter
`timescale 1ns/100ps
`default_nettype none
`include "dpcad_regs.vh"

module dpcad_top #(
  parameter [3:0] JUMPER_ADDR = 4'h0  // high address nibble of the card
) (
  input  wire        ref_clk,      // 10 MHz system clock
  input  wire        reset_n,      // async reset, active low
  input  wire        clk_en,       // freezes state when low
  input  wire        hsel,         // ahb slave select
  input  wire [31:0] haddr,        // ahb address
  input  wire [1:0]  htrans,       // ahb transfer type
  input  wire        hwrite,       // ahb write
  input  wire [2:0]  hsize,        // ahb size, words only
  input  wire [31:0] hwdata,       // ahb write data
  input  wire        hready,       // ahb bus ready
  output wire        hreadyout,    // ahb slave ready
  output wire [31:0] hrdata,       // ahb read data
  output wire        hresp,        // ahb response
  output reg         dev_strobe,   // device command valid
  output reg         dev_write,    // device command is write
  output reg  [6:0]  dev_cmd,      // function and modifier lines
  output reg  [3:0]  dev_addr,     // device address lines
  output reg  [15:0] dev_wdata,    // data toward device
  input  wire        dev_ack,      // device command done
  input  wire [2:0]  dev_cc,       // device completion code
  input  wire [15:0] dev_rdata,    // data from device
  input  wire        dev_in_perr,  // device data parity error
  input  wire [15:0] dev_irq,      // device interrupt requests
  output reg         irq_req,      // interrupt to channel
  output reg  [3:0]  irq_level,    // prepared level
  output reg  [3:0]  irq_dev       // interrupting device address
);

  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_DEV  = 2'b10;

  wire        wr_en;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [7:0]  rd_addr;
  reg  [31:0] rd_data;

  reg  [1:0]  state_q;
  reg  [15:0] cmd_q;       // command byte and device address
  reg  [15:0] imm_q;       // immediate data
  reg  [2:0]  cc_q;        // last completion code
  reg  [15:0] res_q;       // last returned data
  reg         diag_on_q;   // any diagnostic mode
  reg         local_q;     // local-diagnostic mode
  reg  [1:0]  sel_q;       // diagnostic selector
  reg  [3:0]  lvl_q;       // prepared level
  reg         en_q;        // prepared enable
  reg         attn_q;      // attention pending
  reg         operr_q;     // output parity error
  reg         iperr_q;     // input parity error
  reg  [15:0] diag_q;      // diagnostic register

  wire [7:0]  cbyte;
  wire [7:0]  daddr;
  wire        attached;
  wire        is_adapter;
  wire        is_wr;
  wire [15:0] ctl_word;
  wire [15:0] stat_word;
  wire        start;
  wire        perr_in;
  wire [3:0]  pick [0:16];

  // -------------------------------------------------------------------------
  // bus slave
  // -------------------------------------------------------------------------
  dpcad_ahb u_ahb (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
  );

  // -------------------------------------------------------------------------
  // command decode
  // -------------------------------------------------------------------------
  assign cbyte      = cmd_q[7:0];
  assign daddr      = cmd_q[15:8];
  assign attached   = (daddr[7:4] == JUMPER_ADDR);
  // only the five exact adapter codes are taken as adapter commands
  assign is_adapter = (cbyte == `DPCAD_CMD_RD_STATUS) | (cbyte == `DPCAD_CMD_RD_DIAG) |
                      (cbyte == `DPCAD_CMD_PREPARE) | (cbyte == `DPCAD_CMD_SET_DIAG) |
                      (cbyte == `DPCAD_CMD_RST_DIAG);
  assign is_wr      = cbyte[`DPCAD_CMD_WR_BIT];
  // control lines as the devices would see them
  assign ctl_word   = {5'h00, cbyte[6:0], daddr[3:0]};
  // parity bits read zero while local
  assign stat_word  = {operr_q & ~local_q, iperr_q & ~local_q, 12'h000, local_q, diag_on_q};
  assign start      = wr_en & (wr_addr == `DPCAD_OFF_CTRL) & wr_data[`DPCAD_CTRL_START] &
                      state_q[0];
  assign perr_in    = wr_data[`DPCAD_CTRL_PERR];

  // lowest requesting device wins
  assign pick[16] = 4'h0;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_pick
      localparam [3:0] DEV_NUM = gi; // device number of this stage
      assign pick[gi] = dev_irq[gi] ? DEV_NUM : pick[gi+1];
    end
  endgenerate

  // register read mux
  always @* begin
    rd_data = 32'h00000000;
    case (rd_addr)
      `DPCAD_OFF_CMD:    rd_data = {16'h0000, cmd_q};
      `DPCAD_OFF_IMM:    rd_data = {16'h0000, imm_q};
      `DPCAD_OFF_CTRL:   rd_data = {31'h00000000, state_q[1]};
      `DPCAD_OFF_RESULT: rd_data = {state_q[1], 12'h000, cc_q, res_q};
      `DPCAD_OFF_STATE:  rd_data = {stat_word, 6'h00, attn_q, en_q, lvl_q, sel_q,
                                    local_q, diag_on_q};
      `DPCAD_OFF_DIAG:   rd_data = {16'h0000, diag_q};
      `DPCAD_OFF_ATTN:   rd_data = {31'h00000000, attn_q};
      default:           rd_data = 32'h00000000;
    endcase
  end

  // -------------------------------------------------------------------------
  // command execution
  // -------------------------------------------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= S_IDLE;
      cmd_q      <= `DPCAD_RST_CMD;
      imm_q      <= 16'h0000;
      cc_q       <= `DPCAD_CC_OK;
      res_q      <= 16'h0000;
      diag_on_q  <= 1'b0;
      local_q    <= 1'b0;
      sel_q      <= `DPCAD_SEL_ATTN;
      lvl_q      <= `DPCAD_RST_LEVEL;
      en_q       <= `DPCAD_RST_ENABLE;
      attn_q     <= 1'b0;
      operr_q    <= 1'b0;
      iperr_q    <= 1'b0;
      diag_q     <= `DPCAD_RST_DIAG;
      dev_strobe <= 1'b0;
      dev_write  <= 1'b0;
      dev_cmd    <= 7'h00;
      dev_addr   <= 4'h0;
      dev_wdata  <= 16'h0000;
    end else if (clk_en) begin
      // channel services the attention request
      if (wr_en & (wr_addr == `DPCAD_OFF_ATTN) & wr_data[`DPCAD_ATTN_CLR]) begin
        attn_q <= 1'b0;
      end
      if (wr_en & (wr_addr == `DPCAD_OFF_CMD)) begin
        cmd_q <= wr_data[15:0];
      end
      if (wr_en & (wr_addr == `DPCAD_OFF_IMM)) begin
        imm_q <= wr_data[15:0];
      end
      case (state_q)
        S_IDLE: begin
          if (start) begin
            res_q <= 16'h0000;
            if (!attached) begin
              cc_q <= `DPCAD_CC_NOT_ATT;
            end else if (perr_in) begin
              // data check: nothing applied, registers kept
              cc_q    <= `DPCAD_CC_DATA_CHK;
              operr_q <= ~local_q;
            end else if (is_adapter) begin
              // handled here, devices never see it
              cc_q    <= `DPCAD_CC_OK;
              operr_q <= 1'b0;
              iperr_q <= 1'b0;
              case (cbyte)
                `DPCAD_CMD_RD_STATUS: begin
                  res_q <= stat_word;
                end
                `DPCAD_CMD_RD_DIAG: begin
                  res_q <= diag_q;
                end
                `DPCAD_CMD_PREPARE: begin
                  // single level and enable for all devices
                  lvl_q <= imm_q[`DPCAD_IMM_LVL_HI:`DPCAD_IMM_LVL_LO];
                  en_q  <= imm_q[`DPCAD_IMM_EN_BIT];
                end
                `DPCAD_CMD_SET_DIAG: begin
                  diag_on_q <= 1'b1;
                  diag_q    <= `DPCAD_RST_DIAG;
                  local_q   <= ~imm_q[`DPCAD_IMM_EXT_BIT];
                  sel_q     <= imm_q[`DPCAD_IMM_SEL_HI:`DPCAD_IMM_SEL_LO];
                  if (~imm_q[`DPCAD_IMM_EXT_BIT] &
                      (imm_q[`DPCAD_IMM_SEL_HI:`DPCAD_IMM_SEL_LO] == `DPCAD_SEL_ATTN)) begin
                    attn_q <= 1'b1;
                  end
                end
                `DPCAD_CMD_RST_DIAG: begin
                  if (diag_on_q) begin
                    diag_on_q <= 1'b0;
                    local_q   <= 1'b0;
                    sel_q     <= `DPCAD_SEL_ATTN;
                    diag_q    <= `DPCAD_RST_DIAG;
                  end
                end
                default: begin
                  res_q <= 16'h0000;
                end
              endcase
            end else if (local_q) begin
              // answered locally per selector
              // device strobe and lines stay idle here
              cc_q    <= `DPCAD_CC_OK;
              operr_q <= 1'b0;
              iperr_q <= 1'b0;
              case (sel_q)
                `DPCAD_SEL_DATA: begin
                  diag_q <= is_wr ? imm_q : 16'h0000;
                end
                `DPCAD_SEL_LINES: begin
                  diag_q <= ctl_word;
                end
                `DPCAD_SEL_AND: begin
                  diag_q <= is_wr ? (imm_q & ctl_word) : 16'h0000;
                end
                default: begin
                  diag_q <= diag_q;
                end
              endcase
            end else begin
              // pass through unchanged
              state_q    <= S_DEV;
              dev_strobe <= 1'b1;
              dev_write  <= is_wr;
              dev_cmd    <= cbyte[6:0];
              dev_addr   <= daddr[3:0];
              dev_wdata  <= imm_q;
            end
          end
        end
        S_DEV: begin
          if (dev_ack) begin
            state_q    <= S_IDLE;
            dev_strobe <= 1'b0;
            dev_write  <= 1'b0;
            dev_cmd    <= 7'h00;
            dev_addr   <= 4'h0;
            dev_wdata  <= 16'h0000;
            cc_q       <= dev_cc;
            res_q      <= dev_write ? 16'h0000 : dev_rdata;
            if (dev_in_perr) begin
              iperr_q <= 1'b1;
            end else if (dev_cc == `DPCAD_CC_OK) begin
              operr_q <= 1'b0;
              iperr_q <= 1'b0;
            end
            if (diag_on_q) begin
              diag_q <= dev_rdata;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // interrupt request toward the channel
  // -------------------------------------------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_req   <= 1'b0;
      irq_level <= `DPCAD_RST_LEVEL;
      irq_dev   <= 4'h0;
    end else if (clk_en) begin
      // device requests masked while local
      irq_req   <= attn_q | (en_q & ~local_q & (|dev_irq));
      irq_level <= lvl_q;
      irq_dev   <= attn_q ? 4'h0 : pick[0];
    end
  end

endmodule // dpcad_top

`default_nettype wire

// >>> verification/dpcad_asserts.sv
// port checks for the adapter command block
`timescale 1ns/100ps
`default_nettype none
module dpcad_asserts (
  input wire logic        ref_clk,    // clock
  input wire logic        reset_n,    // reset
  input wire logic        clk_en,     // enable
  input wire logic        hsel,       // select
  input wire logic [1:0]  htrans,     // type
  input wire logic        hready,     // bus ready
  input wire logic        hreadyout,  // slave ready
  input wire logic        dev_strobe, // valid
  input wire logic        dev_write,  // direction
  input wire logic [6:0]  dev_cmd,    // command
  input wire logic [3:0]  dev_addr,   // address
  input wire logic [15:0] dev_wdata,  // data out
  input wire logic        dev_ack,    // done
  input wire logic [15:0] dev_irq,    // requests
  input wire logic        irq_req,    // interrupt
  input wire logic [3:0]  irq_dev     // source
);
  logic [15:0] irq_q; // requests one cycle back

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // delayed copy, matches the one-cycle interrupt lag
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) irq_q <= 16'h0000;
    else if (clk_en) irq_q <= dev_irq;
  end

  // handshake steps
  sequence s_take; hsel && hready && htrans[1] && clk_en; endsequence
  sequence s_phase; !hreadyout ##1 hreadyout; endsequence
  sequence s_done; dev_strobe && dev_ack; endsequence

  property p_wait; s_take |=> s_phase; endproperty
  property p_hold; dev_strobe && !dev_ack |=>
    dev_strobe && $stable({dev_write, dev_cmd, dev_addr, dev_wdata}); endproperty
  property p_release; s_done |=> !dev_strobe; endproperty
  property p_dir; dev_strobe |-> dev_write == dev_cmd[6]; endproperty
  property p_own; $rose(dev_strobe) |->
    !(dev_cmd inside {7'h2E, 7'h2F, 7'h60, 7'h61, 7'h62}); endproperty
  property p_idle; !dev_strobe |-> {dev_write, dev_cmd, dev_addr, dev_wdata} == 28'h0; endproperty
  property p_bound; $rose(dev_strobe) |-> ##[1:40] s_done; endproperty
  property p_attn; irq_req && irq_q == 16'h0 |-> irq_dev == 4'h0; endproperty
  property p_low; irq_req && irq_dev != 4'h0 |->
    irq_q[irq_dev] && (irq_q & ((16'h1 << irq_dev) - 16'h1)) == 16'h0; endproperty

  a_wait: assert property (p_wait)
    else $error("data phase is not two cycles");
  a_hold: assert property (p_hold)
    else $error("device lines moved before the answer");
  a_release: assert property (p_release)
    else $error("strobe stayed after the answer");
  a_dir: assert property (p_dir)
    else $error("direction line disagrees with command");
  a_own: assert property (p_own)
    else $error("adapter command reached the devices");
  a_idle: assert property (p_idle)
    else $error("device lines active while idle");
  a_bound: assert property (p_bound)
    else $error("device command never completed");
  a_attn: assert property (p_attn)
    else $error("attention names a device address");
  a_low: assert property (p_low)
    else $error("interrupt source not the lowest request");
endmodule // dpcad_asserts

bind dpcad_top dpcad_asserts u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hreadyout(hreadyout), .dev_strobe(dev_strobe), .dev_write(dev_write),
  .dev_cmd(dev_cmd), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
  .dev_irq(dev_irq), .irq_req(irq_req), .irq_dev(irq_dev)
);
`default_nettype wire

// >>> verification/dpcad_dev_model.sv
// attached device model on the adapter's device side
`timescale 1ns/100ps
`default_nettype none
module dpcad_dev_model (
  input  wire logic        ref_clk,     // clock
  input  wire logic        reset_n,     // reset
  input  wire logic        dev_strobe,  // valid
  input  wire logic        dev_write,   // direction
  input  wire logic [6:0]  dev_cmd,     // command
  input  wire logic [3:0]  dev_addr,    // address
  input  wire logic [15:0] dev_wdata,   // data in
  input  wire logic [2:0]  cfg_cc,      // answer code
  input  wire logic [15:0] cfg_rdata,   // answer data
  input  wire logic [3:0]  cfg_delay,   // answer delay
  input  wire logic        cfg_perr,    // parity fault
  input  wire logic [15:0] cfg_irq,     // requests
  output var  logic        dev_ack,     // done
  output var  logic [2:0]  dev_cc,      // code
  output var  logic [15:0] dev_rdata,   // data out
  output var  logic        dev_in_perr, // parity
  output wire logic [15:0] dev_irq,     // requests
  output var  logic [27:0] last_cmd,    // last command
  output var  logic [7:0]  n_cmd        // answered count
);
  logic [3:0] wait_q; // cycles waited

  assign dev_irq = cfg_irq; // level requests

  // one answer per command after the set delay
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dev_ack <= 1'b0;
      dev_cc <= 3'h0;
      dev_rdata <= 16'h0;
      dev_in_perr <= 1'b0;
      wait_q <= 4'h0;
      last_cmd <= 28'h0;
      n_cmd <= 8'h0;
    end else if (dev_ack) begin
      dev_ack <= 1'b0;
      dev_cc <= ~dev_cc;       // released lines stop showing the answer
      dev_rdata <= ~dev_rdata;
      dev_in_perr <= 1'b0;
    end else if (dev_strobe) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q == cfg_delay) begin
        dev_ack <= 1'b1;
        dev_cc <= cfg_cc;      // any of the eight codes
        dev_rdata <= cfg_rdata;
        dev_in_perr <= cfg_perr;
        wait_q <= 4'h0;
        last_cmd <= {dev_write, dev_cmd, dev_addr, dev_wdata};
        n_cmd <= n_cmd + 8'h1;
      end
    end
  end
endmodule // dpcad_dev_model
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the adapter command block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [18:0] ok = 19'h70000;
  logic        ref_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, cfg_perr = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  cfg_cc = 3'h0, dev_cc;
  logic [3:0]  cfg_delay = 4'h0, dev_addr, irq_level, irq_dev;
  logic [15:0] cfg_rdata = 16'h0, cfg_irq = 16'h0, dev_wdata, dev_rdata, dev_irq;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic        hready, hresp, dev_strobe, dev_write, dev_ack, dev_in_perr, irq_req;
  logic [6:0]  dev_cmd;
  logic [27:0] last_cmd;
  logic [7:0]  n_cmd, n_seen;
  int          err_total = 0, total_checks = 0, cyc = 0, i;

  dpcad_top #(.JUMPER_ADDR(4'h0)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .dev_strobe(dev_strobe),
    .dev_write(dev_write), .dev_cmd(dev_cmd), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_ack(dev_ack), .dev_cc(dev_cc), .dev_rdata(dev_rdata), .dev_in_perr(dev_in_perr),
    .dev_irq(dev_irq), .irq_req(irq_req), .irq_level(irq_level), .irq_dev(irq_dev));
  dpcad_dev_model u_dev (
    .ref_clk(ref_clk), .reset_n(reset_n), .dev_strobe(dev_strobe), .dev_write(dev_write),
    .dev_cmd(dev_cmd), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .cfg_cc(cfg_cc),
    .cfg_rdata(cfg_rdata), .cfg_delay(cfg_delay), .cfg_perr(cfg_perr), .cfg_irq(cfg_irq),
    .dev_ack(dev_ack), .dev_cc(dev_cc), .dev_rdata(dev_rdata), .dev_in_perr(dev_in_perr),
    .dev_irq(dev_irq), .last_cmd(last_cmd), .n_cmd(n_cmd));

  always #50 ref_clk = ~ref_clk;
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      wrap_up;
    end
  end
  // verdict and end of run
  task wrap_up;
    $display("checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // counted comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one single bus transfer, read data left in q
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    q = hrdata;
  endtask
  // register read under a mask
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  // issue one command and poll until not busy
  task run(input logic [7:0] c, input logic [7:0] a, input logic [15:0] d, input logic pe);
    ahb(1'b1, 8'h00, {16'h0, a, c});
    ahb(1'b1, 8'h04, {16'h0, d});
    ahb(1'b1, 8'h08, {30'h0, pe, 1'b1});
    ahb(1'b0, 8'h0C, 32'h0);
    while (q[31] !== 1'b0) ahb(1'b0, 8'h0C, 32'h0);
  endtask
  // command with expected code and returned data
  task cmd(input logic [7:0] c, input logic [7:0] a, input logic [15:0] d, input logic pe,
           input logic [18:0] e);
    run(c, a, d, pe);
    chk({13'h0, q[18:0]}, {13'h0, e});
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    chk({30'h0, hresp, hready}, 32'h1);
    rc(8'h0C, 32'hFFFFFFFF, 32'h00070000);
    rc(8'h10, 32'hFFFFFFFF, 32'h0);
    cmd(8'h60, 8'h00, 16'h0006, 1'b0, ok);
    rc(8'h10, 32'h1F0, 32'h030);
    cmd(8'h60, 8'h00, 16'h0015, 1'b0, ok);
    rc(8'h10, 32'h1F0, 32'h1A0);
    chk({28'h0, irq_level}, 32'hA);
    cmd(8'h60, 8'h00, 16'h0000, 1'b1, 19'h50000);
    rc(8'h10, 32'h800001F0, 32'h800001A0);
    cmd(8'h2E, 8'h00, 16'h0, 1'b0, 19'h78000);
    rc(8'h10, 32'h80000000, 32'h0);
    cmd(8'h60, 8'h10, 16'h0006, 1'b0, 19'h00000);
    rc(8'h10, 32'h1F0, 32'h1A0);
    for (i = 0; i < 8; i++) begin
      cfg_cc <= i[2:0];
      cfg_rdata <= 16'h1230 + i[15:0];
      cfg_delay <= i[3:0];
      cmd(8'h05, 8'h03, 16'h0, 1'b0, {i[2:0], 16'h1230 + i[15:0]});
    end
    cmd(8'h45, 8'h03, 16'hBEEF, 1'b0, ok);
    chk({4'h0, last_cmd}, {4'h0, 1'b1, 7'h45, 4'h3, 16'hBEEF});
    cfg_perr <= 1'b1;
    run(8'h05, 8'h03, 16'h0, 1'b0);
    cfg_perr <= 1'b0;
    rc(8'h10, 32'h40000000, 32'h40000000);
    cmd(8'h60, 8'h00, 16'h0015, 1'b0, ok);
    rc(8'h10, 32'h40000000, 32'h0);
    cfg_irq <= 16'h0060;
    repeat (3) @(posedge ref_clk);
    chk({27'h0, irq_req, irq_dev}, 32'h15);
    cmd(8'h61, 8'h00, 16'h0001, 1'b0, ok);
    rc(8'h10, 32'h0003000F, 32'h00030007);
    rc(8'h14, 32'hFFFF, 32'h0);
    chk({31'h0, irq_req}, 32'h0);
    n_seen = n_cmd;
    cmd(8'h45, 8'h03, 16'hC3C3, 1'b0, ok);
    rc(8'h14, 32'hFFFF, 32'hC3C3);
    cmd(8'h2F, 8'h00, 16'h0, 1'b0, 19'h7C3C3);
    cmd(8'h45, 8'h03, 16'h1111, 1'b1, 19'h50000);
    rc(8'h14, 32'hFFFF, 32'hC3C3);
    rc(8'h10, 32'hC0000000, 32'h0);
    cmd(8'h05, 8'h03, 16'h0, 1'b0, ok);
    rc(8'h14, 32'hFFFF, 32'h0);
    chk({24'h0, n_cmd}, {24'h0, n_seen});
    cmd(8'h61, 8'h00, 16'h0002, 1'b0, ok);
    cmd(8'h45, 8'h03, 16'hFFFF, 1'b0, ok);
    rc(8'h14, 32'hFFFF, 32'h0453);
    cmd(8'h61, 8'h00, 16'h0003, 1'b0, ok);
    cmd(8'h45, 8'h03, 16'h0F0F, 1'b0, ok);
    rc(8'h14, 32'hFFFF, 32'h0403);
    cmd(8'h62, 8'h00, 16'h0, 1'b0, ok);
    rc(8'h14, 32'hFFFF, 32'h0);
    rc(8'h10, 32'h3, 32'h0);
    cmd(8'h61, 8'h00, 16'h0000, 1'b0, ok);
    repeat (2) @(posedge ref_clk);
    chk({27'h0, irq_req, irq_dev}, 32'h10);
    ahb(1'b1, 8'h18, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq_req}, 32'h0);
    cmd(8'h62, 8'h00, 16'h0, 1'b0, ok);
    cmd(8'h62, 8'h00, 16'h0, 1'b0, ok);
    repeat (2) @(posedge ref_clk);
    chk({27'h0, irq_req, irq_dev}, 32'h15);
    rc(8'h40, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
